// *** rtl/dapt_pkg.sv ***
// package: register map, reset values and field positions for the aux pwm timer
package dapt_pkg;
  localparam logic [11:0] DAPT_OFF_MODE = 12'h000;
  localparam logic [11:0] DAPT_OFF_PER0 = 12'h004;
  localparam logic [11:0] DAPT_OFF_PER1 = 12'h008;
  localparam logic [11:0] DAPT_OFF_ON0 = 12'h00C;
  localparam logic [11:0] DAPT_OFF_ON1 = 12'h010;
  localparam logic [11:0] DAPT_OFF_STAT = 12'h014;
  localparam int DAPT_MODE_INDEP_BIT = 8;
  localparam logic [15:0] DAPT_PER_RST = 16'hFFFF;
  localparam logic [15:0] DAPT_ON_RST = 16'h0000;
  localparam logic DAPT_MODE_RST = 1'b0;
  localparam int DAPT_TICK_DIV = 2;
endpackage

// *** rtl/dapt_tick_div.sv ***
// divider: one-cycle tick every DIV core clocks, restartable
module dapt_tick_div
  import dapt_pkg::*;
#(
  parameter int DIV = DAPT_TICK_DIV
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic restart,
  output logic tick
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  always_comb begin
    cnt_d = cnt_q + 8'h01;
    if (restart || cnt_q == 8'(DIV - 1)) begin
      cnt_d = 8'h00;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign tick = (cnt_q == 8'(DIV - 1)) && !restart;
endmodule

// *** rtl/dapt_channel.sv ***
// one pwm channel: period counter, latched on-time, output flop
module dapt_channel (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic restart,
  input wire logic start_ext,
  input wire logic use_ext,
  input wire logic [15:0] period,
  input wire logic [15:0] on_time,
  output logic cycle_start,
  output logic pwm_out
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [16:0] on_q;
  logic [16:0] on_d;
  logic [16:0] hi_q;
  logic [16:0] hi_d;
  logic out_q;
  logic out_d;
  logic start;
  assign cycle_start = tick && (cnt_q == 16'h0000);
  assign start = use_ext ? start_ext : cycle_start;
  always_comb begin
    cnt_d = cnt_q;
    on_d = on_q;
    hi_d = hi_q;
    out_d = out_q;
    if (restart) begin
      cnt_d = 16'h0000;
      hi_d = 17'h00000;
      out_d = 1'b0;
    end else if (tick) begin
      cnt_d = (cnt_q >= period) ? 16'h0000 : cnt_q + 16'h0001;
      if (start) begin
        on_d = {1'b0, on_time};
        hi_d = (on_time == 16'h0000) ? 17'h00000 : {1'b0, on_time} - 17'h00001;
        out_d = (on_time != 16'h0000);
      end else if (hi_q != 17'h00000) begin
        hi_d = hi_q - 17'h00001;
      end else if (on_q <= {1'b0, period}) begin
        out_d = 1'b0;
      end
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
      on_q <= 17'h00000;
      hi_q <= 17'h00000;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      on_q <= on_d;
      hi_q <= hi_d;
      out_q <= out_d;
    end
  end
  assign pwm_out = out_q;
endmodule

// *** rtl/dapt_top.sv ***
// top: apb registers and two auxiliary pwm channels
module dapt_top
  import dapt_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic aux_output_zero,
  output logic aux_output_one
);
  logic [15:0] mode_q;
  logic [15:0] mode_d;
  logic [15:0] per0_q;
  logic [15:0] per0_d;
  logic [15:0] per1_q;
  logic [15:0] per1_d;
  logic [15:0] on0_q;
  logic [15:0] on0_d;
  logic [15:0] on1_q;
  logic [15:0] on1_d;
  logic [16:0] offs_q;
  logic [16:0] offs_d;
  logic offs_run_q;
  logic offs_run_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic restart_q;
  logic restart_d;
  logic wr;
  logic rd;
  logic mapped;
  logic indep;
  logic tick;
  logic start0;
  logic start1_ind;
  logic offs_hit;

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == DAPT_OFF_MODE) || (a == DAPT_OFF_PER0) || (a == DAPT_OFF_PER1) ||
              (a == DAPT_OFF_ON0) || (a == DAPT_OFF_ON1) || (a == DAPT_OFF_STAT);
  endfunction

  assign mapped = addr_ok(paddr);
  assign wr = psel && penable && pwrite && mapped;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign indep = mode_q[DAPT_MODE_INDEP_BIT];

  always_comb begin
    mode_d = mode_q;
    per0_d = per0_q;
    per1_d = per1_q;
    on0_d = on0_q;
    on1_d = on1_q;
    restart_d = 1'b0;
    rd_d = rd_q;
    if (wr) begin
      unique case (paddr)
        DAPT_OFF_MODE: mode_d = pwdata[15:0];
        DAPT_OFF_PER0: begin
          per0_d = pwdata[15:0];
          restart_d = 1'b1;
        end
        DAPT_OFF_PER1: begin
          per1_d = pwdata[15:0];
          restart_d = 1'b1;
        end
        DAPT_OFF_ON0: on0_d = pwdata[15:0];
        DAPT_OFF_ON1: on1_d = pwdata[15:0];
        default: ;
      endcase
    end
    if (rd) begin
      rd_d = 32'h00000000;
      case (paddr)
        DAPT_OFF_MODE: rd_d[15:0] = mode_q;
        DAPT_OFF_PER0: rd_d[15:0] = per0_q;
        DAPT_OFF_PER1: rd_d[15:0] = per1_q;
        DAPT_OFF_ON0: rd_d[15:0] = on0_q;
        DAPT_OFF_ON1: rd_d[15:0] = on1_q;
        DAPT_OFF_STAT: rd_d[2:0] = {offs_run_q, aux_output_one, aux_output_zero};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= 16'(DAPT_MODE_RST) << DAPT_MODE_INDEP_BIT;
      per0_q <= DAPT_PER_RST;
      per1_q <= DAPT_PER_RST;
      on0_q <= DAPT_ON_RST;
      on1_q <= DAPT_ON_RST;
      restart_q <= 1'b0;
      rd_q <= 32'h00000000;
    end else begin
      mode_q <= mode_d;
      per0_q <= per0_d;
      per1_q <= per1_d;
      on0_q <= on0_d;
      on1_q <= on1_d;
      restart_q <= restart_d;
      rd_q <= rd_d;
    end
  end
  assign prdata = rd_q;

  // a mode change also restarts so the two channels realign
  logic mode_chg;
  assign mode_chg = wr && (paddr == DAPT_OFF_MODE) &&
                    (pwdata[DAPT_MODE_INDEP_BIT] != indep);

  dapt_tick_div #(
    .DIV(DAPT_TICK_DIV)
  ) u_div (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .restart(restart_q || mode_chg),
    .tick(tick)
  );

  // offset delay: counts per1+1 ticks from output zero's cycle start
  assign offs_hit = offs_run_q && tick && (offs_q == 17'h00000);
  always_comb begin
    offs_d = offs_q;
    offs_run_d = offs_run_q;
    if (restart_q || mode_chg || indep) begin
      offs_run_d = 1'b0;
      offs_d = 17'h00000;
    end else if (tick) begin
      if (start0) begin
        offs_run_d = 1'b1;
        offs_d = {1'b0, per1_q};
      end else if (offs_hit) begin
        offs_run_d = 1'b0;
      end else if (offs_run_q) begin
        offs_d = offs_q - 17'h00001;
      end
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      offs_q <= 17'h00000;
      offs_run_q <= 1'b0;
    end else begin
      offs_q <= offs_d;
      offs_run_q <= offs_run_d;
    end
  end

  dapt_channel u_ch0 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(tick),
    .restart(restart_q || mode_chg),
    .start_ext(1'b0),
    .use_ext(1'b0),
    .period(per0_q),
    .on_time(on0_q),
    .cycle_start(start0),
    .pwm_out(aux_output_zero)
  );

  dapt_channel u_ch1 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(tick),
    .restart(restart_q || mode_chg),
    .start_ext(offs_hit),
    .use_ext(!indep),
    .period(indep ? per1_q : per0_q),
    .on_time(on1_q),
    .cycle_start(start1_ind),
    .pwm_out(aux_output_one)
  );
endmodule

// *** testbench/dapt_top_sva.sv ***
// checker: bus and pulse properties of the aux pwm timer
module dapt_top_sva
  import dapt_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic aux_output_zero,
  input wire logic aux_output_one
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_rise0;
    !aux_output_zero ##1 aux_output_zero;
  endsequence
  a_ready_high: assert property (pready) else $error("ready low");
  a_unmapped_err: assert property (s_acc ##0 paddr > DAPT_OFF_STAT |-> pslverr)
    else $error("no error");
  a_mapped_ok: assert property (s_acc ##0 paddr == DAPT_OFF_PER0 |-> !pslverr)
    else $error("false error");
  a_upper_zero: assert property (s_acc ##0 !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper bits");
  a_high_zero: assert property (s_rise0 |-> aux_output_zero[*2])
    else $error("short high");
  a_low_zero: assert property ($fell(aux_output_zero) |-> !aux_output_zero[*2])
    else $error("short low");
  a_high_one: assert property ($rose(aux_output_one) |=> aux_output_one)
    else $error("short high");
  a_low_one: assert property (aux_output_one ##1 !aux_output_one |=> !aux_output_one)
    else $error("short low");
endmodule
bind dapt_top dapt_top_sva u_sva (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .aux_output_zero(aux_output_zero),
  .aux_output_one(aux_output_one));

// *** testbench/dapt_load.sv ***
// partner: load on one pwm pin, times each pulse and period
module dapt_load (
  input wire logic mclk,
  input wire logic arm,
  input wire logic pin,
  output logic done,
  output logic [31:0] meas
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last, seen;
  logic [15:0] per, hi;
  always @(posedge mclk) begin
    done <= 1'b0;
    last <= pin;
    per <= per + 16'h0001;
    hi <= hi + {15'h0000, pin};
    if (!arm) seen <= 1'b0;
    if (arm && pin && !last) begin
      {seen, done, meas} <= {1'b1, seen, per, hi};
      {per, hi} <= {16'h0001, 16'h0001};
    end
  end
endmodule

// *** testbench/tb_dapt_top.sv ***
// testbench: register, pulse and offset checks for the aux pwm timer
module tb_dapt_top
  import dapt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, arm = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, m0, m1, rv;
  logic pready, pslverr, aux_output_zero, aux_output_one, d0, d1, er;
  logic [31:0] q0 [$], q1 [$];
  logic [15:0] p0, p1;
  int n_fail = 0, checks_done = 0, n;
  always #2.5 mclk = ~mclk;
  dapt_top dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aux_output_zero(aux_output_zero), .aux_output_one(aux_output_one));
  dapt_load u_l0 (.mclk(mclk), .arm(arm), .pin(aux_output_zero), .done(d0), .meas(m0));
  dapt_load u_l1 (.mclk(mclk), .arm(arm), .pin(aux_output_one), .done(d1), .meas(m1));
  task end_sim;
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task hang;
    n_fail++;
    end_sim;
  endtask
  task cmp(input logic [31:0] e, input logic [31:0] a);
    checks_done++;
    if (a !== e) begin
      n_fail++;
      $display("wrong value at %0t: expected %h got %h", $time, e, a);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge mclk); while (pready !== 1'b1 && ++n < 50);
    rv = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) hang;
  endtask
  task wt(input logic ch, input logic v);
    n = 0;
    while ((ch ? aux_output_one : aux_output_zero) !== v && n < 100) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 100) hang;
  endtask
  task cfg(input logic [31:0] md, input logic [15:0] a, b, c, d);
    xfer(1'b1, DAPT_OFF_ON0, 32'h0);
    xfer(1'b1, DAPT_OFF_ON1, 32'h0);
    repeat (40) @(posedge mclk);
    xfer(1'b1, DAPT_OFF_MODE, md);
    xfer(1'b1, DAPT_OFF_PER0, {16'h0000, a});
    xfer(1'b1, DAPT_OFF_PER1, {16'h0000, b});
    xfer(1'b1, DAPT_OFF_ON0, {16'h0000, c});
    xfer(1'b1, DAPT_OFF_ON1, {16'h0000, d});
    repeat (40) @(posedge mclk);
    arm <= 1'b1;
    repeat (3) begin
      q0.push_back({16'(2 * (a + 1)), 16'(2 * c)});
      q1.push_back({md[DAPT_MODE_INDEP_BIT] ? 16'(2 * (b + 1)) : 16'(2 * (a + 1)), 16'(2 * d)});
    end
    n = 0;
    while (q0.size() + q1.size() > 0 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 2000) hang;
    arm <= 1'b0;
  endtask
  always @(posedge mclk) begin
    if (d0 === 1'b1 && q0.size() > 0) cmp(q0.pop_front(), m0);
    if (d1 === 1'b1 && q1.size() > 0) cmp(q1.pop_front(), m1);
  end
  initial begin
    void'($urandom(74));
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, 12'(4 * i), 32'h0);
      cmp((i == 1 || i == 2) ? {16'h0000, DAPT_PER_RST} : 32'h0, rv);
    end
    xfer(1'b0, DAPT_OFF_STAT + 12'h004, 32'h0);
    cmp(32'h1, {31'h0, er});
    p0 = 16'(2 + $urandom % 6);
    p1 = 16'(2 + $urandom % 6);
    cfg(32'h100, p0, p1, 16'(1 + $urandom % p0), 16'(1 + $urandom % p1));
    cfg(32'h0, 16'h0007, 16'h0002, 16'h0003, 16'h0005);
    wt(1'b0, 1'b0);
    wt(1'b0, 1'b1);
    wt(1'b1, 1'b1);
    cmp(2 * (2 + 1), n);
    xfer(1'b1, DAPT_OFF_ON0, 32'h0008);
    xfer(1'b1, DAPT_OFF_ON1, 32'h0000);
    repeat (40) @(negedge mclk);
    repeat (20) begin
      @(negedge mclk);
      cmp(32'h2, {30'h0, aux_output_zero, aux_output_one});
    end
    end_sim;
  end
endmodule
